//--- design/regulator_one_control_regs.sv
`timescale 1ns/1ns
// How it works
// (RULE1) Bit 14 of control picks regulation when clear and a current-limited switch when set.
// (RULE2) Bit 10 of control clear discharges the disabled output, set leaves it floating.
// (RULE3) When all four regulators are off every output is discharged regardless of bit 10.
// (RULE4) The active code maps upper half to 1.8-3.3 V in 100 mV and lower to 0.9-1.65 V in 50 mV.
// (RULE5) Fault response 00 ignores, 01 stops this regulator, 10 and 11 stop the system.
// (RULE6) Every fault raises an interrupt event whatever the response field holds.
// (RULE7) Start-up code 0 means never, 1 to 14 a slot, 15 on entering active.
// (RULE8) Shutdown code 1 to 14 means a slot, 0 and 15 mean on entering off.
// (RULE9) Hibernate behaviour 00 applies the image code, 01 disables the output, rest reserved.
// (RULE10) Hibernate source 00 is the software bit, 01 to 11 are low-power inputs one to three.
// (RULE11) The image code uses the same voltage mapping as the active code.
// (RULE12) A state-machine reset returns all fields to their fixed defaults; the code leaves the interrupt mask and software hibernate bit unchanged.
// (RULE13) In hibernate with behaviour 00 the target follows the image code, else the active code.
module regulator_one_control_regs
	import regulator_one_pkg::*;
(
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [ADDR_W-1:0] paddr_in,
	input  wire logic [31:0]       pwdata_in,
	input  wire logic [3:0]        pstrb_in,
	output logic      [31:0]       prdata_out,
	output logic                   pready_out,
	output logic                   pslverr_out,
	input  wire logic              sm_reset_in,
	input  wire logic              regulator_on_in,
	input  wire logic              others_disabled_in,
	input  wire logic              fault_in,
	input  wire logic              low_power_input_one_in,
	input  wire logic              low_power_input_two_in,
	input  wire logic              low_power_input_three_in,
	output logic                   irq_out,
	output logic                   regulator_enable_out,
	output logic                   switch_mode_out,
	output logic                   discharge_out,
	output logic      [4:0]        voltage_code_out,
	output logic      [11:0]       voltage_mv_out,
	output logic                   fault_regulator_off_out,
	output logic                   fault_system_off_out,
	output logic                   hibernate_out,
	output slot_plan_t             startup_plan_out,
	output slot_plan_t             shutdown_plan_out
);

	// ----------------------------------------
	// Voltage mapping
	// ----------------------------------------
	function automatic logic [11:0] code_to_mv(input logic [4:0] code);
		logic [11:0] step;
		step = {8'h00, code[3:0]};
		if (code[4])
			code_to_mv = 12'(HIGH_BASE_MV + step * HIGH_STEP_MV);
		else
			code_to_mv = 12'(LOW_BASE_MV + step * LOW_STEP_MV);
	endfunction : code_to_mv

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [15:0]      ctrl_q;
	logic [15:0]      timeout_q;
	logic [15:0]      lowpwr_q;
	logic [IRQ_W-1:0] irq_status_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic             hib_sw_q;
	logic             fault_prev_q;
	logic             hib_prev_q;
	logic             fault_off_q;

	// ----------------------------------------
	// Pin inputs
	// ----------------------------------------
	logic fault_lvl, lp_one, lp_two, lp_three;

	input_sync fault_sync (.clock_in(clock_in), .rst_in(rst_in),
		.raw_in(fault_in), .level_out(fault_lvl));
	input_sync lp_one_sync (.clock_in(clock_in), .rst_in(rst_in),
		.raw_in(low_power_input_one_in), .level_out(lp_one));
	input_sync lp_two_sync (.clock_in(clock_in), .rst_in(rst_in),
		.raw_in(low_power_input_two_in), .level_out(lp_two));
	input_sync lp_three_sync (.clock_in(clock_in), .rst_in(rst_in),
		.raw_in(low_power_input_three_in), .level_out(lp_three));

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic        access;
	logic        start;
	logic        commit;
	logic        hit_ctrl, hit_timeout, hit_lowpwr, hit_status;
	logic        hit_mask, hit_hib_sw, hit_state, hit_any;
	logic        wr;
	logic [15:0] wbe;
	logic [15:0] rd_word;
	logic [15:0] state_word;

	assign access      = psel_in && penable_in;
	// One wait state: pready rises in the second access cycle
	assign start       = access && !pready_out;
	assign commit      = access && pready_out;
	assign hit_ctrl    = (paddr_in == {CTRL_INDEX, 2'h0});
	assign hit_timeout = (paddr_in == {TIMEOUT_INDEX, 2'h0});
	assign hit_lowpwr  = (paddr_in == {LOWPWR_INDEX, 2'h0});
	assign hit_status  = (paddr_in == {IRQ_STATUS_INDEX, 2'h0});
	assign hit_mask    = (paddr_in == {IRQ_MASK_INDEX, 2'h0});
	assign hit_hib_sw  = (paddr_in == {HIB_SW_INDEX, 2'h0});
	assign hit_state   = (paddr_in == {STATE_INDEX, 2'h0});
	assign hit_any     = hit_ctrl || hit_timeout || hit_lowpwr || hit_status
		|| hit_mask || hit_hib_sw || hit_state;
	assign wr          = commit && pwrite_in && hit_any;
	assign wbe         = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

	// ----------------------------------------
	// Field views
	// ----------------------------------------
	logic        switch_sel;
	logic        float_sel;
	logic [4:0]  active_voltage_code;
	fault_resp_t fault_response_select;
	logic [3:0]  startup_slot_select;
	logic [3:0]  shutdown_slot_select;
	hib_beh_t    hibernate_behaviour_select;
	hib_src_t    hibernate_source_select;
	logic [4:0]  image_voltage_code;

	assign switch_sel                 = ctrl_q[SWITCH_BIT];
	assign float_sel                  = ctrl_q[FLOAT_BIT];
	assign active_voltage_code        = ctrl_q[VCODE_LSB +: 5];
	assign fault_response_select      = fault_resp_t'(timeout_q[FAULT_LSB +: 2]);
	assign startup_slot_select        = timeout_q[START_LSB +: 4];
	assign shutdown_slot_select       = timeout_q[STOP_LSB +: 4];
	assign hibernate_behaviour_select = hib_beh_t'(lowpwr_q[HIBB_LSB +: 2]);
	assign hibernate_source_select    = hib_src_t'(lowpwr_q[HIBS_LSB +: 2]);
	assign image_voltage_code         = lowpwr_q[IMG_LSB +: 5];

	// ----------------------------------------
	// Hibernate and regulator state
	// ----------------------------------------
	logic       hib_sel;
	logic       hib_image;
	logic       hib_off;
	logic       fault_rise;
	logic       hib_rise;
	logic       reg_on;
	logic       all_off;
	logic       discharge_d;
	logic [4:0] code_d;
	logic [11:0] mv_d;

	// (RULE10) Hibernate source mux
	always_comb
	begin
		hib_sel = 1'h0;
		unique case (hibernate_source_select)
			HIB_SRC_SW:  hib_sel = hib_sw_q;
			HIB_SRC_LP1: hib_sel = lp_one;
			HIB_SRC_LP2: hib_sel = lp_two;
			HIB_SRC_LP3: hib_sel = lp_three;
		endcase
	end

	// (RULE9) Reserved behaviour codes leave active settings
	assign hib_image  = hib_sel && (hibernate_behaviour_select == HIB_IMAGE);
	assign hib_off    = hib_sel && (hibernate_behaviour_select == HIB_DISABLE);
	assign fault_rise = fault_lvl && !fault_prev_q;
	assign hib_rise   = hib_sel && !hib_prev_q;
	assign reg_on     = regulator_on_in && !fault_off_q && !hib_off;
	// (RULE3) All four off forces discharge
	assign all_off    = !reg_on && others_disabled_in;
	// (RULE2) Float bit only matters while disabled
	assign discharge_d = !reg_on && (!float_sel || all_off);
	// (RULE13) Image code wins only in image hibernate
	assign code_d     = hib_image ? image_voltage_code : active_voltage_code;
	// (RULE1) Switch mode, voltage code has no effect; (RULE4) (RULE11) shared mapping
	assign mv_d       = switch_sel ? 12'h000 : code_to_mv(code_d);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	assign state_word = {6'h00, fault_off_q, fault_lvl, discharge_out,
		regulator_enable_out, hib_sel, code_d};

	assign rd_word = hit_ctrl    ? ctrl_q :
		hit_timeout ? timeout_q :
		hit_lowpwr  ? lowpwr_q :
		hit_status  ? {14'h0000, irq_status_q} :
		hit_mask    ? {14'h0000, irq_mask_q} :
		hit_hib_sw  ? {15'h0000, hib_sw_q} :
		hit_state   ? state_word : 16'h0000;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	logic [15:0]      ctrl_d;
	logic [15:0]      timeout_d;
	logic [15:0]      lowpwr_d;
	logic [IRQ_W-1:0] w1c;
	logic [IRQ_W-1:0] events;
	logic [IRQ_W-1:0] irq_status_d;

	assign ctrl_d    = (ctrl_q & ~(wbe & CTRL_WMASK)) | (pwdata_in[15:0] & wbe & CTRL_WMASK);
	assign timeout_d = (timeout_q & ~(wbe & TIMEOUT_WMASK))
		| (pwdata_in[15:0] & wbe & TIMEOUT_WMASK);
	assign lowpwr_d  = (lowpwr_q & ~(wbe & LOWPWR_WMASK))
		| (pwdata_in[15:0] & wbe & LOWPWR_WMASK);
	assign w1c       = (wr && hit_status && pstrb_in[0]) ? pwdata_in[IRQ_W-1:0] : '0;
	// (RULE6) Fault event is raised whatever the response
	assign events    = {hib_rise, fault_rise};
	// Set beats clear in the same cycle
	assign irq_status_d = (irq_status_q & ~w1c) | events;

	// (RULE12) State-machine reset reloads the fixed defaults
	always_ff @(posedge clock_in)
	begin
		if (rst_in || sm_reset_in)
		begin
			ctrl_q    <= CTRL_RESET;
			timeout_q <= TIMEOUT_RESET;
			lowpwr_q  <= LOWPWR_RESET;
		end
		else if (wr)
		begin
			ctrl_q    <= hit_ctrl    ? ctrl_d    : ctrl_q;
			timeout_q <= hit_timeout ? timeout_d : timeout_q;
			lowpwr_q  <= hit_lowpwr  ? lowpwr_d  : lowpwr_q;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			irq_mask_q <= '0;
			hib_sw_q   <= 1'h0;
		end
		else if (wr && pstrb_in[0])
		begin
			irq_mask_q <= hit_mask   ? pwdata_in[IRQ_W-1:0] : irq_mask_q;
			hib_sw_q   <= hit_hib_sw ? pwdata_in[0] : hib_sw_q;
		end
	end

	// ----------------------------------------
	// Bus answer and events
	// ----------------------------------------
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			pready_out   <= 1'h0;
			pslverr_out  <= 1'h0;
			prdata_out   <= 32'h0000_0000;
			irq_status_q <= '0;
			irq_out      <= 1'h0;
		end
		else
		begin
			pready_out   <= start;
			pslverr_out  <= start && !hit_any;
			prdata_out   <= start ? {16'h0000, rd_word} : prdata_out;
			irq_status_q <= irq_status_d;
			irq_out      <= |(irq_status_d & irq_mask_q);
		end
	end

	// (RULE5) Regulator stop latches until a state-machine reset
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			fault_prev_q         <= 1'h0;
			hib_prev_q           <= 1'h0;
			fault_off_q          <= 1'h0;
			fault_system_off_out <= 1'h0;
		end
		else
		begin
			fault_prev_q         <= fault_lvl;
			hib_prev_q           <= hib_sel;
			fault_off_q          <= (fault_rise && fault_response_select == FAULT_REG_OFF)
				|| (fault_off_q && !sm_reset_in);
			fault_system_off_out <= fault_rise && fault_response_select[1];
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			regulator_enable_out    <= 1'h0;
			switch_mode_out         <= 1'h0;
			discharge_out           <= 1'h0;
			voltage_code_out        <= 5'h00;
			voltage_mv_out          <= 12'h000;
			fault_regulator_off_out <= 1'h0;
			hibernate_out           <= 1'h0;
		end
		else
		begin
			regulator_enable_out    <= reg_on;
			switch_mode_out         <= switch_sel;
			discharge_out           <= discharge_d;
			voltage_code_out        <= code_d;
			voltage_mv_out          <= mv_d;
			fault_regulator_off_out <= fault_off_q;
			hibernate_out           <= hib_sel;
		end
	end

	// (RULE7) Start-up plan decode
	slot_plan_decode #(.IS_SHUTDOWN(1'h0)) startup_decode (.clock_in(clock_in),
		.rst_in(rst_in), .code_in(startup_slot_select), .plan_out(startup_plan_out));
	// (RULE8) Shutdown plan decode
	slot_plan_decode #(.IS_SHUTDOWN(1'h1)) shutdown_decode (.clock_in(clock_in),
		.rst_in(rst_in), .code_in(shutdown_slot_select), .plan_out(shutdown_plan_out));

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	switch_mv_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE1
		switch_mode_out |-> voltage_mv_out == 12'h000)
		else $error("switch mode shows a voltage");
	// Outputs hold their reset value one edge past release, so skip that cycle
	float_discharge_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE2
		$past(!reg_on && !float_sel && !rst_in) |-> discharge_out && !regulator_enable_out)
		else $error("disabled output not discharged");
	all_off_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE3
		$past(!reg_on && others_disabled_in && !rst_in) |-> discharge_out)
		else $error("all regulators off without discharge");
	mv_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE4
		!switch_mode_out && voltage_code_out == 5'h10 |-> voltage_mv_out == 12'h708)
		else $error("code 10 not 1800 mV");
	fault_sys_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE5
		fault_rise && fault_response_select[1] |=> fault_system_off_out ##1 !fault_system_off_out)
		else $error("system stop pulse wrong");
	fault_irq_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE6
		fault_rise |=> irq_status_q[IRQ_FAULT_BIT])
		else $error("fault did not raise event");
	startup_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE7
		startup_slot_select == 4'hF |=> startup_plan_out.at_state && !startup_plan_out.none)
		else $error("start code 15 not on active");
	shutdown_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE8
		shutdown_slot_select == 4'h0 |=> shutdown_plan_out.at_state)
		else $error("stop code 0 not on off");
	hib_disable_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE9
		$past(hib_off) |-> !regulator_enable_out)
		else $error("hibernate disable left output on");
	hib_source_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE10
		hibernate_source_select == HIB_SRC_SW && hib_sw_q |=> hibernate_out)
		else $error("software hibernate ignored");
	sm_reset_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE12
		sm_reset_in |=> ctrl_q == CTRL_RESET && lowpwr_q == LOWPWR_RESET)
		else $error("defaults not reloaded");
	image_target_a: assert property (@(posedge clock_in) disable iff (rst_in) // RULE13
		$past(hib_image) |-> voltage_code_out == $past(image_voltage_code))
		else $error("image code not applied");

endmodule : regulator_one_control_regs

//--- design/regulator_one_pkg.sv
package regulator_one_pkg;

	// ----------------------------------------
	// Register map (index, byte address = 4 x index)
	// ----------------------------------------
	localparam int unsigned ADDR_W           = 10;
	localparam logic [7:0]  CTRL_INDEX       = 8'hC8;
	localparam logic [7:0]  TIMEOUT_INDEX    = 8'hC9;
	localparam logic [7:0]  LOWPWR_INDEX     = 8'hCA;
	localparam logic [7:0]  IRQ_STATUS_INDEX = 8'hF0;
	localparam logic [7:0]  IRQ_MASK_INDEX   = 8'hF1;
	localparam logic [7:0]  HIB_SW_INDEX     = 8'hF2;
	localparam logic [7:0]  STATE_INDEX      = 8'hF3;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int unsigned SWITCH_BIT = 14;
	localparam int unsigned FLOAT_BIT  = 10;
	localparam int unsigned VCODE_LSB  = 0;
	localparam int unsigned FAULT_LSB  = 14;
	localparam int unsigned START_LSB  = 10;
	localparam int unsigned STOP_LSB   = 6;
	localparam int unsigned HIBB_LSB   = 12;
	localparam int unsigned HIBS_LSB   = 8;
	localparam int unsigned IMG_LSB    = 0;

	// Writable bits; all others read as zero
	localparam logic [15:0] CTRL_WMASK    = 16'h441F;
	localparam logic [15:0] TIMEOUT_WMASK = 16'hFFC0;
	localparam logic [15:0] LOWPWR_WMASK  = 16'h331F;

	// Mask-held defaults
	localparam logic [15:0] CTRL_RESET    = 16'h001C;
	localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
	localparam logic [15:0] LOWPWR_RESET  = 16'h001C;

	// Interrupt status and mask layout
	localparam int unsigned IRQ_W         = 2;
	localparam int unsigned IRQ_FAULT_BIT = 0;
	localparam int unsigned IRQ_HIB_BIT   = 1;

	// Voltage mapping in mV: 900, 50, 1800, 100
	localparam logic [11:0] LOW_BASE_MV   = 12'h384;
	localparam logic [11:0] LOW_STEP_MV   = 12'h032;
	localparam logic [11:0] HIGH_BASE_MV  = 12'h708;
	localparam logic [11:0] HIGH_STEP_MV  = 12'h064;

	typedef enum logic [1:0] {
		FAULT_IGNORE   = 2'b00,
		FAULT_REG_OFF  = 2'b01,
		FAULT_SYS_OFF  = 2'b10,
		FAULT_SYS_RSVD = 2'b11
	} fault_resp_t;

	typedef enum logic [1:0] {
		HIB_SRC_SW  = 2'b00,
		HIB_SRC_LP1 = 2'b01,
		HIB_SRC_LP2 = 2'b10,
		HIB_SRC_LP3 = 2'b11
	} hib_src_t;

	typedef enum logic [1:0] {
		HIB_IMAGE   = 2'b00,
		HIB_DISABLE = 2'b01,
		HIB_RSVD2   = 2'b10,
		HIB_RSVD3   = 2'b11
	} hib_beh_t;

	typedef struct packed {
		logic       none;
		logic       at_state;
		logic [3:0] slot;
	} slot_plan_t;

endpackage : regulator_one_pkg

//--- design/input_sync.sv
`timescale 1ns/1ns
// Three-stage sync; output moves only when stages two and three agree
module input_sync
	import regulator_one_pkg::*;
(
	input  wire logic clock_in,
	input  wire logic rst_in,
	input  wire logic raw_in,
	output logic      level_out
);

	logic stage1_q;
	logic stage2_q;
	logic stage3_q;
	logic level_d;

	assign level_d = (stage2_q == stage3_q) ? stage3_q : level_out;

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			stage1_q  <= 1'h0;
			stage2_q  <= 1'h0;
			stage3_q  <= 1'h0;
			level_out <= 1'h0;
		end
		else
		begin
			stage1_q  <= raw_in;
			stage2_q  <= stage1_q;
			stage3_q  <= stage2_q;
			level_out <= level_d;
		end
	end

endmodule : input_sync

//--- design/slot_plan_decode.sv
`timescale 1ns/1ns
// Turns a four-bit slot code into a sequencer plan
module slot_plan_decode
	import regulator_one_pkg::*;
#(
	parameter bit IS_SHUTDOWN = 1'h0
)
(
	input  wire logic       clock_in,
	input  wire logic       rst_in,
	input  wire logic [3:0] code_in,
	output slot_plan_t      plan_out
);

	logic       code_zero;
	logic       code_full;
	slot_plan_t plan_d;

	assign code_zero       = (code_in == 4'h0);
	assign code_full       = (code_in == 4'hF);
	assign plan_d.none     = code_zero && !IS_SHUTDOWN;
	assign plan_d.at_state = code_full || (code_zero && IS_SHUTDOWN);
	assign plan_d.slot     = (code_zero || code_full) ? 4'h0 : code_in;

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			plan_out <= '0;
		else
			plan_out <= plan_d;
	end

endmodule : slot_plan_decode

//--- bench/regulator_one_control_regs_bench.sv
`timescale 1ns/1ns
module regulator_one_control_regs_bench
	import regulator_one_pkg::*;
;
	logic             clock_in = 1'b0;
	logic             rst_in   = 1'b1;
	logic             psel_q   = 1'b0;
	logic             pen_q    = 1'b0;
	logic             pwr_q    = 1'b0;
	logic [9:0]       paddr_q  = 10'h000;
	logic [31:0]      pwd_q    = 32'h0;
	logic [3:0]       pstrb_q  = 4'hF;
	logic             sm_q     = 1'b0;
	logic             on_q     = 1'b0;
	logic             oth_q    = 1'b0;
	logic             flt_q    = 1'b0;
	logic [2:0]       lp_q     = 3'h0;
	logic [31:0]      prdata;
	logic             pready, pslverr, irq, en, sw, dis, freg, fsys, hib;
	logic [4:0]       vcode;
	logic [11:0]      mv;
	slot_plan_t       sp, dp;
	int               n_fail = 0;
	int               check_count = 0;
	int               cycles = 0;
	int               pulses = 0;
	logic [31:0]      rng = 32'h10;

	always #10 clock_in = ~clock_in;

	regulator_one_control_regs i_dut (
		.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel_q), .penable_in(pen_q),
		.pwrite_in(pwr_q), .paddr_in(paddr_q), .pwdata_in(pwd_q), .pstrb_in(pstrb_q),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.sm_reset_in(sm_q), .regulator_on_in(on_q), .others_disabled_in(oth_q),
		.fault_in(flt_q), .low_power_input_one_in(lp_q[0]),
		.low_power_input_two_in(lp_q[1]), .low_power_input_three_in(lp_q[2]),
		.irq_out(irq), .regulator_enable_out(en), .switch_mode_out(sw),
		.discharge_out(dis), .voltage_code_out(vcode), .voltage_mv_out(mv),
		.fault_regulator_off_out(freg), .fault_system_off_out(fsys),
		.hibernate_out(hib), .startup_plan_out(sp), .shutdown_plan_out(dp)
	);

	// ----------------------------------------
	// Bench helpers
	// ----------------------------------------
	task complete_run;
		$display("Comparisons %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	// Hang guard, well above the expected run of under a thousand cycles
	always @(posedge clock_in)
	begin
		cycles++;
		if (fsys === 1'b1)
			pulses++;
		if (cycles == 12000)
		begin
			n_fail++;
			complete_run();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xorshift

	// Upper half 100 mV from 1800, lower half 50 mV from 900
	function automatic logic [31:0] mv_of(input logic [4:0] c);
		return c[4] ? 32'h708 + 32'h64 * c[3:0] : 32'h384 + 32'h32 * c;
	endfunction : mv_of

	task automatic idle(input int n);
		repeat (n) @(posedge clock_in);
	endtask : idle

	// Request held until pready is sampled high or 20 cycles pass
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clock_in);
		psel_q  <= 1'b1;
		pen_q   <= 1'b0;
		pwr_q   <= w;
		paddr_q <= {idx, 2'b00};
		pwd_q   <= d;
		@(posedge clock_in);
		pen_q <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock_in);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd  = prdata;
		err = pslverr;
		psel_q <= 1'b0;
		pen_q  <= 1'b0;
		check("pready", pready, 32'h1);
	endtask : xfer

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] rd;
		logic        e;
		xfer(1'b1, idx, d, rd, e);
		check("write err", e, 32'h0);
	endtask : wr

	task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] rd;
		logic        e;
		xfer(1'b0, idx, exp, rd, e);
		check(nm, rd, exp);
	endtask : rdchk

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] rd;
		logic        e;
		logic [31:0] m;
		logic [4:0]  img;
		int          k;
		idle(6);
		rst_in <= 1'b0;
		rdchk("ctrl", CTRL_INDEX, 32'h1C);
		rdchk("timeouts", TIMEOUT_INDEX, 32'h0);
		rdchk("low power", LOWPWR_INDEX, 32'h1C);
		xfer(1'b0, 8'hC7, 32'h0, rd, e);
		check("unmapped err", e, 32'h1);
		check("unmapped data", rd, 32'h0);
		for (k = 0; k < 12; k++)
		begin
			rng = xorshift(rng);
			m = (k % 3 == 0) ? 32'h441F : (k % 3 == 1) ? 32'hFFC0 : 32'h331F;
			wr(CTRL_INDEX + 8'(k % 3), rng);
			rdchk("readback", CTRL_INDEX + 8'(k % 3), rng & m);
		end
		wr(CTRL_INDEX, 32'h4405);
		sm_q <= 1'b1;
		idle(1);
		sm_q <= 1'b0;
		rdchk("reload", CTRL_INDEX, 32'h1C);
		on_q <= 1'b1;
		for (k = 0; k < 32; k++)
		begin
			wr(CTRL_INDEX, 32'(k));
			idle(3);
			check("code", vcode, 32'(k));
			check("mv", mv, mv_of(5'(k)));
		end
		wr(CTRL_INDEX, 32'h401F);
		idle(3);
		check("switch", sw, 32'h1);
		check("switch mv", mv, 32'h0);
		pstrb_q <= 4'hE;
		wr(CTRL_INDEX, 32'h0005);
		pstrb_q <= 4'hF;
		rdchk("lane", CTRL_INDEX, 32'h1F);
		on_q <= 1'b0;
		for (k = 0; k < 4; k++)
		begin
			wr(CTRL_INDEX, k[0] ? 32'h400 : 32'h0);
			oth_q <= k[1];
			idle(3);
			check("discharge", dis, 32'(!k[0] || k[1]));
		end
		oth_q <= 1'b0;
		for (k = 0; k < 16; k++)
		begin
			wr(TIMEOUT_INDEX, 32'((k << 10) | (k << 6)));
			idle(3);
			check("start", {sp.none, sp.at_state}, {k == 0, k == 15});
			if (k != 0 && k != 15)
				check("start slot", sp.slot, 32'(k));
			check("stop", {dp.none, dp.at_state}, {1'b0, k == 0 || k == 15});
			if (k != 0 && k != 15)
				check("stop slot", dp.slot, 32'(k));
		end
		on_q <= 1'b1;
		wr(CTRL_INDEX, 32'h10);
		for (k = 0; k < 4; k++)
		begin
			rng = xorshift(rng);
			img = rng[4:0];
			wr(LOWPWR_INDEX, 32'((k << 8) | img));
			idle(8);
			check("hib idle", hib, 32'h0);
			check("active", vcode, 32'h10);
			if (k == 0)
				wr(HIB_SW_INDEX, 32'h1);
			else
				lp_q <= 3'(1 << (k - 1));
			idle(8);
			check("hib", hib, 32'h1);
			check("image", vcode, 32'(img));
			check("image mv", mv, mv_of(img));
			wr(HIB_SW_INDEX, 32'h0);
			lp_q <= 3'h0;
			idle(8);
		end
		wr(LOWPWR_INDEX, 32'h1000);
		wr(HIB_SW_INDEX, 32'h1);
		idle(4);
		check("hib off", en, 32'h0);
		wr(HIB_SW_INDEX, 32'h0);
		idle(4);
		check("hib on", en, 32'h1);
		wr(LOWPWR_INDEX, 32'h2000);
		wr(HIB_SW_INDEX, 32'h1);
		idle(4);
		check("rsvd on", en, 32'h1);
		check("rsvd code", vcode, 32'h10);
		wr(HIB_SW_INDEX, 32'h0);
		wr(IRQ_STATUS_INDEX, 32'h3);
		wr(IRQ_MASK_INDEX, 32'h1);
		for (k = 0; k < 4; k++)
		begin
			wr(TIMEOUT_INDEX, 32'(k << 14));
			pulses = 0;
			flt_q <= 1'b1;
			idle(10);
			rdchk("status", IRQ_STATUS_INDEX, 32'h1);
			check("irq", irq, 32'h1);
			check("reg off", freg, 32'(k == 1));
			flt_q <= 1'b0;
			idle(6);
			check("sys off", pulses, 32'(k >> 1));
			wr(IRQ_STATUS_INDEX, 32'h1);
			idle(2);
			check("irq clear", irq, 32'h0);
			sm_q <= 1'b1;
			idle(1);
			sm_q <= 1'b0;
			idle(3);
			check("latch reset", freg, 32'h0);
		end
		wr(IRQ_MASK_INDEX, 32'h0);
		flt_q <= 1'b1;
		idle(10);
		check("masked", irq, 32'h0);
		rdchk("masked status", IRQ_STATUS_INDEX, 32'h1);
		flt_q <= 1'b0;
		wr(IRQ_MASK_INDEX, 32'h1);
		idle(2);
		check("unmasked", irq, 32'h1);
		complete_run();
	end
endmodule : regulator_one_control_regs_bench
